// ==== design/bgs_bridge_ctrl.sv ====
// Gate control and short protection for two H-bridges, with APB registers.
// Assumes pins are asynchronous to CLK; bridge polarity comes from chopper logic on CLK.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bgs_bridge_ctrl
  import bgs_pkg::*;
#(
  parameter int PAUSE_CYC = RETRY_PAUSE_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Disable pin and polarity from chopper, index 0,1 coil A, 2,3 coil B
  input wire logic HW_DISABLE,
  input wire logic [3:0] WANT_HS,
  // Gate discharged sense pins
  input wire logic [3:0] HS_GATE_OFF,
  input wire logic [3:0] LS_GATE_OFF,
  // Short comparators: coil reached level, low-side drop too high
  input wire logic [3:0] HS_LEVEL_OK,
  input wire logic [3:0] LS_OVERCURRENT,
  // Gate commands and analog settings
  output logic [3:0] HS_ON,
  output logic [3:0] LS_ON,
  output bgs_drive_s DRIVE,
  output logic HS_SENS_HIGH,
  output logic [1:0] SHORT_FLAGS
);
  // ==========================================================
  // Pin synchronisers
  logic [16:0] pins_s;
  logic dis_s;
  logic [3:0] hs_off_s, ls_off_s, lvl_ok_s, ovc_s;

  bgs_sync3 #(.W(17)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in({HW_DISABLE, HS_GATE_OFF, LS_GATE_OFF, HS_LEVEL_OK, LS_OVERCURRENT}),
    .sync_out(pins_s)
  );
  assign {dis_s, hs_off_s, ls_off_s, lvl_ok_s, ovc_s} = pins_s;

  // ==========================================================
  // APB registers
  bgs_ctrl_s ctrl_reg, ctrl_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic [1:0] flag_reg;
  logic [1:0] retry_view [2];
  logic setup, hit_ctrl, hit_stat;

  assign setup = PSEL && !PENABLE;
  assign hit_ctrl = PADDR == CTRL_OFS;
  assign hit_stat = PADDR == STAT_OFS;

  always_comb begin
    ctrl_next = ctrl_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (PSEL && PENABLE && PWRITE && hit_ctrl) begin
      ctrl_next = PWDATA[CTRL_USED_W-1:0];
    end
    if (setup) begin
      err_next = !(hit_ctrl || hit_stat);
      rdata_next = 32'h0000_0000;
      if (hit_ctrl) begin
        rdata_next[CTRL_USED_W-1:0] = ctrl_reg;
      end else if (hit_stat) begin
        rdata_next[7:0] = {retry_view[1], retry_view[0], 2'h0, flag_reg};
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RESET[CTRL_USED_W-1:0];
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  // Zero wait states; read data captured in the setup cycle
  assign PREADY = 1'b1;
  assign PRDATA = rdata_reg;
  assign PSLVERR = PSEL && PENABLE && err_reg;

  // ==========================================================
  // Drive strength decode, registered so the analog side sees no glitch
  bgs_drive_s drive_reg, drive_next;

  always_comb begin
    case (ctrl_reg.low_side_drive_strength)
      2'h2: drive_next.ls_level = DRV_MED;
      2'h3: drive_next.ls_level = DRV_MAX;
      default: drive_next.ls_level = DRV_MIN;
    endcase
    drive_next.hs_temp_comp = 1'b0;
    case (ctrl_reg.high_side_drive_strength)
      2'h0: drive_next.hs_level = DRV_MIN;
      2'h1: begin
        drive_next.hs_level = DRV_MIN;
        drive_next.hs_temp_comp = 1'b1;
      end
      2'h2: begin
        drive_next.hs_level = DRV_MED;
        drive_next.hs_temp_comp = 1'b1;
      end
      default: drive_next.hs_level = DRV_MAX;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end
  assign DRIVE = drive_reg;
  assign HS_SENS_HIGH = ctrl_reg.overcurrent_sensitivity_sel;

  // ==========================================================
  // Enable and detection delay
  logic bridge_en;
  logic [7:0] dly_cyc;
  assign bridge_en = !dis_s && (ctrl_reg.slow_decay_off_time != 4'h0);

  always_comb begin
    case (ctrl_reg.short_detect_delay_sel)
      2'h0: dly_cyc = 8'(DLY_3U2_CYC);
      2'h1: dly_cyc = 8'(DLY_1U6_CYC);
      2'h2: dly_cyc = 8'(DLY_1U2_CYC);
      default: dly_cyc = 8'(DLY_0U8_CYC);
    endcase
  end

  // ==========================================================
  // Per half-bridge on-time check
  logic [3:0] hb_ena, hb_fault, hs_evt, ls_evt;

  for (genvar h = 0; h < 4; h++) begin : g_hb
    logic [7:0] cnt_reg, cnt_next;
    logic side_reg, side_next;
    logic timed;

    bgs_half_bridge u_hb (
      .clk(CLK),
      .rst_n(RST_N),
      .ena(hb_ena[h]),
      .want_hs(WANT_HS[h]),
      .hs_gate_off(hs_off_s[h]),
      .ls_gate_off(ls_off_s[h]),
      .hs_on(HS_ON[h]),
      .ls_on(LS_ON[h])
    );

    // Counter restarts on every new conduction phase
    always_comb begin
      side_next = HS_ON[h];
      cnt_next = cnt_reg;
      if (!(HS_ON[h] || LS_ON[h]) || side_reg != HS_ON[h]) begin
        cnt_next = 8'h00;
      end else if (cnt_reg != 8'hFF) begin
        cnt_next = cnt_reg + 8'h01;
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        cnt_reg <= 8'h00;
        side_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_next;
        side_reg <= side_next;
      end
    end

    assign timed = (side_reg == HS_ON[h]) && (cnt_reg == dly_cyc);
    assign hs_evt[h] = HS_ON[h] && timed && !lvl_ok_s[h]
                       && !ctrl_reg.ground_short_detect_off;
    assign ls_evt[h] = LS_ON[h] && timed && ovc_s[h]
                       && ctrl_reg.supply_short_detect_on;
    assign hb_fault[h] = hs_evt[h] || ls_evt[h];

    a_gnd_det_off: assert property (@(posedge CLK) disable iff (!RST_N)
      ctrl_reg.ground_short_detect_off |-> !hs_evt[h])
      else $error("ground short detected while disabled");
    a_supply_det_off: assert property (@(posedge CLK) disable iff (!RST_N)
      !ctrl_reg.supply_short_detect_on |-> !ls_evt[h])
      else $error("supply short detected while not enabled");
  end

  // ==========================================================
  // Per coil retry and shutdown
  for (genvar c = 0; c < 2; c++) begin : g_coil
    bgs_coil_e st_reg, st_next;
    logic [1:0] try_reg, try_next;
    logic [CNT_W-1:0] wait_reg, wait_next;
    logic flag_next;
    logic flag_bit_reg;
    logic fault;

    assign fault = hb_fault[2*c] || hb_fault[2*c+1];

    always_comb begin
      st_next = st_reg;
      try_next = try_reg;
      wait_next = wait_reg;
      flag_next = flag_reg[c];
      case (st_reg)
        CS_RUN: begin
          if (fault && try_reg == 2'(RETRY_MAX)) begin
            st_next = CS_SHUT;
            flag_next = 1'b1;
          end else if (fault) begin
            st_next = CS_PAUSE;
            try_next = try_reg + 2'h1;
            wait_next = CNT_W'(PAUSE_CYC);
          end
        end
        CS_PAUSE: begin
          if (wait_reg == '0) begin
            st_next = CS_RUN;
          end else begin
            wait_next = wait_reg - 1'b1;
          end
        end
        CS_SHUT: st_next = CS_SHUT;
        default: st_next = CS_RUN;
      endcase
      // Disable wipes the history so re-enable restarts cleanly
      if (!bridge_en) begin
        st_next = CS_RUN;
        try_next = 2'h0;
        wait_next = '0;
        flag_next = 1'b0;
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        st_reg <= CS_RUN;
        try_reg <= 2'h0;
        wait_reg <= '0;
        flag_bit_reg <= 1'b0;
      end else begin
        st_reg <= st_next;
        try_reg <= try_next;
        wait_reg <= wait_next;
        flag_bit_reg <= flag_next;
      end
    end
    assign flag_reg[c] = flag_bit_reg;

    assign hb_ena[2*c] = bridge_en && st_reg == CS_RUN && !fault;
    assign hb_ena[2*c+1] = hb_ena[2*c];
    assign retry_view[c] = try_reg;

    a_shut_coil_off: assert property (@(posedge CLK) disable iff (!RST_N)
      flag_reg[c] |-> ##1 !(HS_ON[2*c] || LS_ON[2*c] || HS_ON[2*c+1] || LS_ON[2*c+1]))
      else $error("shut coil still driven");
    a_flag_needs_try: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(flag_reg[c]) |-> $past(try_reg) == 2'h3)
      else $error("flag set before three retries");
  end

  assign SHORT_FLAGS = flag_reg;

  // ==========================================================
  // Checks on disable paths and the low-side drive decode
  a_hw_dis_off: assert property (@(posedge CLK) disable iff (!RST_N)
    dis_s |-> ##1 (HS_ON == 4'h0 && LS_ON == 4'h0))
    else $error("bridges driven during hardware disable");
  a_slow_decay_off_time_zero_off: assert property (@(posedge CLK) disable iff (!RST_N)
    ctrl_reg.slow_decay_off_time == 4'h0 |-> ##1 (HS_ON == 4'h0 && LS_ON == 4'h0))
    else $error("bridges driven with zero off time");
  a_flag_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    !bridge_en |-> ##1 SHORT_FLAGS == 2'h0)
    else $error("short flags not cleared by disable");
  a_ls_decode: assert property (@(posedge CLK) disable iff (!RST_N)
    ctrl_reg.low_side_drive_strength == 2'h2 |=> DRIVE.ls_level == DRV_MED)
    else $error("low side strength decode wrong");
endmodule : bgs_bridge_ctrl
`default_nettype wire

// ==== design/bgs_pkg.sv ====
// Shared constants, register map and types for the bridge gate and short protection block.
// Assumes a 40 MHz system clock and an APB register port with 32-bit data.
package bgs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int DLY_3U2_NS = 3200;
  localparam int DLY_1U6_NS = 1600;
  localparam int DLY_1U2_NS = 1200;
  localparam int DLY_0U8_NS = 800;
  localparam int DLY_3U2_CYC = (DLY_3U2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_1U6_CYC = (DLY_1U6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_1U2_CYC = (DLY_1U2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_0U8_CYC = (DLY_0U8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_PAUSE_NS = 10000;
  localparam int RETRY_PAUSE_CYC = (RETRY_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_MAX = 3;
  localparam int CNT_W = 16;

  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_USED_W = 13;

  // ==========================================================
  // Encodings
  localparam logic [1:0] DRV_MIN = 2'h0;
  localparam logic [1:0] DRV_MED = 2'h1;
  localparam logic [1:0] DRV_MAX = 2'h2;

  // Control register layout, bit 12 downward
  typedef struct packed {
    logic overcurrent_sensitivity_sel;
    logic supply_short_detect_on;
    logic [1:0] short_detect_delay_sel;
    logic ground_short_detect_off;
    logic [1:0] high_side_drive_strength;
    logic [1:0] low_side_drive_strength;
    logic [3:0] slow_decay_off_time;
  } bgs_ctrl_s;

  // Gate driver strength toward the analog drivers
  typedef struct packed {
    logic [1:0] ls_level;
    logic [1:0] hs_level;
    logic hs_temp_comp;
  } bgs_drive_s;

  typedef enum logic [1:0] {CS_RUN, CS_PAUSE, CS_SHUT} bgs_coil_e;
endpackage : bgs_pkg

// ==== design/bgs_sync3.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pins are quasi-static relative to a few clock cycles.
`timescale 1ns/1ps
`default_nettype none
module bgs_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and filtered result
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg, out_next;

  // Change accepted only once stages two and three agree
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule : bgs_sync3
`default_nettype wire

// ==== design/bgs_half_bridge.sv ====
// Break-before-make sequencing for one half-bridge.
// Assumes gate-discharged sense inputs are already synchronised.
`timescale 1ns/1ps
`default_nettype none
module bgs_half_bridge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command
  input wire logic ena,
  input wire logic want_hs,
  // Gate sense, high when that gate is discharged
  input wire logic hs_gate_off,
  input wire logic ls_gate_off,
  // Gate on commands
  output logic hs_on,
  output logic ls_on
);
  logic hs_reg, hs_next, ls_reg, ls_next;

  // A side only turns on once the opposite gate is sensed discharged
  always_comb begin
    hs_next = ena && want_hs && (hs_reg || (!ls_reg && ls_gate_off));
    ls_next = ena && !want_hs && (ls_reg || (!hs_reg && hs_gate_off));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
    end else begin
      hs_reg <= hs_next;
      ls_reg <= ls_next;
    end
  end

  assign hs_on = hs_reg;
  assign ls_on = ls_reg;

  a_no_cross_cond: assert property (@(posedge clk) disable iff (!rst_n) !(hs_on && ls_on))
    else $error("both transistors of a half-bridge on");
  a_bbm_hs_turnon: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(hs_on) |-> $past(ls_gate_off) && !$past(ls_on))
    else $error("high side on before low gate discharged");
  a_bbm_ls_turnon: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ls_on) |-> $past(hs_gate_off) && !$past(hs_on))
    else $error("low side on before high gate discharged");
endmodule : bgs_half_bridge
`default_nettype wire

// ==== dv/bgs_fet_model.sv ====
// Behavioural model of the four external half-bridges and their sense lines.
// Assumes gate commands arrive on CLK; faults are injected by the bench.
`timescale 1ns/1ps
`default_nettype none
module bgs_fet_model #(
  parameter int LAG = 6,
  parameter int RISE = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Gate commands and injected faults
  input wire logic [3:0] hs_on,
  input wire logic [3:0] ls_on,
  input wire logic [3:0] short_gnd,
  input wire logic [3:0] short_vs,
  // Sense lines back to the block
  output logic [3:0] hs_gate_off,
  output logic [3:0] ls_gate_off,
  output logic [3:0] hs_level_ok,
  output logic [3:0] ls_overcurrent
);
  logic [3:0] hs_q;
  logic [3:0] ls_q;
  logic [3:0] hc [4];
  logic [3:0] lc [4];
  // ==========
  // Cycles since each gate command last changed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_q <= 4'h0;
      ls_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        hc[i] <= 4'hF;
        lc[i] <= 4'hF;
      end
    end else begin
      hs_q <= hs_on;
      ls_q <= ls_on;
      for (int i = 0; i < 4; i++) begin
        hc[i] <= (hs_on[i] != hs_q[i]) ? 4'h0 : hc[i] + 4'(hc[i] != 4'hF);
        lc[i] <= (ls_on[i] != ls_q[i]) ? 4'h0 : lc[i] + 4'(lc[i] != 4'hF);
      end
    end
  end
  // ==========
  // Gates lag their command, so sense stays low while charge drains
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hs_gate_off[i] = !hs_q[i] && hc[i] >= LAG;
      ls_gate_off[i] = !ls_q[i] && lc[i] >= LAG;
      hs_level_ok[i] = hs_q[i] && hc[i] >= RISE && !short_gnd[i];
      ls_overcurrent[i] = ls_q[i] && lc[i] >= RISE && short_vs[i];
    end
  end
endmodule : bgs_fet_model
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the bridge gate and short protection block.
// Assumes the bridge model in bgs_fet_model and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench import bgs_pkg::*;;
  localparam int LAG = 6;
  logic CLK = 1'b0;
  logic RST_N = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic HW_DISABLE = 1'b0;
  logic [3:0] WANT_HS = 4'h0;
  logic [3:0] short_gnd = 4'h0;
  logic [3:0] short_vs = 4'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic HS_SENS_HIGH;
  logic [1:0] SHORT_FLAGS;
  logic [3:0] HS_GATE_OFF, LS_GATE_OFF, HS_LEVEL_OK, LS_OVERCURRENT, HS_ON, LS_ON;
  bgs_drive_s DRIVE;
  bgs_ctrl_s ctrl;
  logic [31:0] rdata;
  logic rerr;
  int n_errors = 0;
  int checked = 0;
  wire logic [9:0] mon = {SHORT_FLAGS, LS_ON, HS_ON};

  bgs_bridge_ctrl #(.PAUSE_CYC(10)) dut_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .HW_DISABLE(HW_DISABLE), .WANT_HS(WANT_HS),
    .HS_GATE_OFF(HS_GATE_OFF), .LS_GATE_OFF(LS_GATE_OFF), .HS_LEVEL_OK(HS_LEVEL_OK),
    .LS_OVERCURRENT(LS_OVERCURRENT), .HS_ON(HS_ON), .LS_ON(LS_ON), .DRIVE(DRIVE),
    .HS_SENS_HIGH(HS_SENS_HIGH), .SHORT_FLAGS(SHORT_FLAGS));
  bgs_fet_model #(.LAG(LAG), .RISE(3)) fet_u (.clk(CLK), .rst_n(RST_N), .hs_on(HS_ON),
    .ls_on(LS_ON), .short_gnd(short_gnd), .short_vs(short_vs), .hs_gate_off(HS_GATE_OFF),
    .ls_gate_off(LS_GATE_OFF), .hs_level_ok(HS_LEVEL_OK), .ls_overcurrent(LS_OVERCURRENT));

  always #12.5 CLK = ~CLK;

  // ==========
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  // Brief polarity swap starts fresh conduction phases, so the delay check runs again
  task automatic flip(input logic [3:0] v);
    WANT_HS <= v;
    cyc(20);
    WANT_HS <= 4'h1;
  endtask : flip
  task automatic wb(input int b, input logic v, output int n);
    n = 0;
    while (mon[b] !== v && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 3000) check(32'h0, 32'h1, "wait");
  endtask : wb
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wr_ctrl();
    apb(1'b1, CTRL_OFS, 32'(ctrl));
  endtask : wr_ctrl

  // ==========
  // Both sides never on; a side turns on only over a discharged opposite gate
  always @(posedge CLK) begin
    check(32'(HS_ON & LS_ON), 32'h0, "both on");
    check(32'({HS_ON & ~LS_GATE_OFF, LS_ON & ~HS_GATE_OFF}), 32'h0, "bbm");
  end

  // ==========
  // Scenarios
  task automatic t_reset();
    check(32'({HS_ON, LS_ON, DRIVE, HS_SENS_HIGH, SHORT_FLAGS}), 32'h0, "rst outs");
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rdata, CTRL_RESET, "ctrl rst");
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    apb(1'b0, 8'h08, 32'h0);
    check({rdata[30:0], rerr}, 32'h1, "unmapped");
    apb(1'b1, STAT_OFS, 32'hFF);
    apb(1'b0, STAT_OFS, 32'h0);
    check({rdata[30:0], rerr}, 32'h0, "status ro");
    WANT_HS <= 4'h5;
    cyc(20);
    check(32'({HS_ON, LS_ON}), 32'h0, "slow_decay_off_time 0");
    $display("test reset done");
  endtask : t_reset
  task automatic t_drive();
    logic [1:0] lvl [4] = '{DRV_MIN, DRV_MIN, DRV_MED, DRV_MAX};
    logic [3:0] tc = 4'b0110;
    for (int c = 0; c < 4; c++) begin
      ctrl = '0;
      ctrl.low_side_drive_strength = 2'(c);
      ctrl.high_side_drive_strength = 2'(3 - c);
      ctrl.overcurrent_sensitivity_sel = c[0];
      wr_ctrl();
      apb(1'b0, CTRL_OFS, 32'h0);
      check(rdata, 32'(ctrl), "ctrl rb");
      check(32'(DRIVE.ls_level), 32'(lvl[c]), "ls drv");
      check(32'({DRIVE.hs_level, DRIVE.hs_temp_comp}), 32'({lvl[3-c], tc[3-c]}), "hs drv");
      check(32'(HS_SENS_HIGH), 32'(c[0]), "sens");
    end
    $display("test drive done");
  endtask : t_drive
  task automatic t_bbm();
    int n;
    ctrl = '0;
    ctrl.slow_decay_off_time = 4'h1;
    ctrl.ground_short_detect_off = 1'b1;
    wr_ctrl();
    wb(0, 1'b1, n);
    cyc(10);
    WANT_HS <= 4'hA;
    wb(4, 1'b1, n);
    check(32'(n > LAG), 32'h1, "bbm wait");
    cyc(10);
    check(32'({HS_ON, LS_ON}), 32'hA5, "swapped");
    HW_DISABLE <= 1'b1;
    cyc(10);
    check(32'({HS_ON, LS_ON}), 32'h0, "hw dis");
    HW_DISABLE <= 1'b0;
    wb(1, 1'b1, n);
    ctrl.slow_decay_off_time = 4'h0;
    wr_ctrl();
    cyc(3);
    check(32'({HS_ON, LS_ON}), 32'h0, "slow_decay_off_time dis");
    $display("test bbm done");
  endtask : t_bbm
  task automatic t_delay();
    int d [4] = '{DLY_3U2_CYC, DLY_1U6_CYC, DLY_1U2_CYC, DLY_0U8_CYC};
    int n;
    int w;
    short_gnd <= 4'h1;
    WANT_HS <= 4'h1;
    for (int s = 0; s < 4; s++) begin
      ctrl = '0;
      ctrl.slow_decay_off_time = 4'h1;
      // Every delay here exceeds the model's rise time
      ctrl.short_detect_delay_sel = 2'(s);
      wr_ctrl();
      wb(0, 1'b1, n);
      wb(0, 1'b0, w);
      check(32'(w >= d[s] && w <= d[s] + 4), 32'h1, "delay");
      check(32'(LS_ON[3:2]), 32'h3, "coil b on");
      apb(1'b0, STAT_OFS, 32'h0);
      check(rdata, 32'h10, "one retry");
      ctrl.slow_decay_off_time = 4'h0;
      wr_ctrl();
      apb(1'b0, STAT_OFS, 32'h0);
      check(rdata, 32'h0, "retry clr");
    end
    $display("test delay done");
  endtask : t_delay
  task automatic t_persist();
    int n;
    ctrl.slow_decay_off_time = 4'h1;
    wr_ctrl();
    for (int k = 0; k < 4; k++) begin
      check(32'(SHORT_FLAGS), 32'h0, "early flag");
      wb(0, 1'b1, n);
      wb(0, 1'b0, n);
    end
    cyc(3);
    check(32'(SHORT_FLAGS), 32'h1, "flag a");
    apb(1'b0, STAT_OFS, 32'h0);
    check(rdata, 32'h31, "status");
    cyc(100);
    check(32'({HS_ON, LS_ON}), 32'h0C, "a off");
    short_gnd <= 4'h0;
    HW_DISABLE <= 1'b1;
    cyc(10);
    check(32'(SHORT_FLAGS), 32'h0, "flag clr");
    apb(1'b0, STAT_OFS, 32'h0);
    check(rdata, 32'h0, "cnt clr");
    // Disable then enable restarts the coil
    HW_DISABLE <= 1'b0;
    wb(0, 1'b1, n);
    cyc(100);
    check(32'({HS_ON, LS_ON}), 32'h1E, "resumed");
    $display("test persist done");
  endtask : t_persist
  task automatic t_detect_off();
    int n;
    short_gnd <= 4'h1;
    ctrl.ground_short_detect_off = 1'b1;
    wr_ctrl();
    flip(4'h0);
    cyc(300);
    check(32'({SHORT_FLAGS, HS_ON[0]}), 32'h1, "gnd off");
    short_gnd <= 4'h0;
    short_vs <= 4'h2;
    ctrl.ground_short_detect_off = 1'b0;
    wr_ctrl();
    flip(4'h3);
    cyc(300);
    check(32'({SHORT_FLAGS, LS_ON[1]}), 32'h1, "vs off");
    ctrl.supply_short_detect_on = 1'b1;
    wr_ctrl();
    flip(4'h3);
    wb(8, 1'b1, n);
    cyc(2);
    check(32'({SHORT_FLAGS, LS_ON[1:0], HS_ON[1:0]}), 32'h10, "vs short");
    ctrl.slow_decay_off_time = 4'h0;
    wr_ctrl();
    cyc(2);
    check(32'(SHORT_FLAGS), 32'h0, "slow_decay_off_time clr");
    short_vs <= 4'h0;
    $display("test detect done");
  endtask : t_detect_off

  // ==========
  // Main sequence and watchdog
  initial begin
    RST_N <= 1'b0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_drive();
    t_bbm();
    t_delay();
    t_persist();
    t_detect_off();
    end_of_test();
  end
  initial begin
    #(25.0 * 30000);
    n_errors++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
